// File: design/lcc_top.sv
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module lcc_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [63:0] SOURCES,
  output logic             CELL_OUT,
  output logic             CELL_IRQ_FLAG
);
  lcc_pkg::lcc_state_type s_q;
  lcc_pkg::lcc_state_type s_d;
  logic                   rise;
  logic                   fall;
  logic                   irq_set;
  logic                   irq_clr;
  logic [3:0]             widx;
  logic [3:0]             ridx;
  logic [7:0]             wbyte;
  logic [7:0]             rbyte;

  lcc_core_if cif ();

  lcc_core u_core (
    .clk (SYS_CLK),
    .rst (RST),
    .cif (cif)
  );

  // word-aligned decode shared by the write and read paths
  function automatic logic [3:0] map_index(input logic [7:0] addr);
    case (addr)
      lcc_pkg::CELL_CONTROL_ADDR:   map_index = lcc_pkg::IDX_CONTROL;
      lcc_pkg::CELL_POLARITY_ADDR:  map_index = lcc_pkg::IDX_POLARITY;
      lcc_pkg::INPUT_SELECT_0_ADDR: map_index = lcc_pkg::IDX_SELECT0;
      lcc_pkg::INPUT_SELECT_1_ADDR: map_index = lcc_pkg::IDX_SELECT0 + 4'h1;
      lcc_pkg::INPUT_SELECT_2_ADDR: map_index = lcc_pkg::IDX_SELECT0 + 4'h2;
      lcc_pkg::INPUT_SELECT_3_ADDR: map_index = lcc_pkg::IDX_SELECT0 + 4'h3;
      lcc_pkg::GATE_ENABLE_0_ADDR:  map_index = lcc_pkg::IDX_GATE0;
      lcc_pkg::GATE_ENABLE_1_ADDR:  map_index = lcc_pkg::IDX_GATE0 + 4'h1;
      lcc_pkg::GATE_ENABLE_2_ADDR:  map_index = lcc_pkg::IDX_GATE0 + 4'h2;
      lcc_pkg::GATE_ENABLE_3_ADDR:  map_index = lcc_pkg::IDX_GATE0 + 4'h3;
      lcc_pkg::CELL_IRQ_ADDR:       map_index = lcc_pkg::IDX_IRQ;
      default:                      map_index = lcc_pkg::IDX_NONE;
    endcase
  endfunction : map_index

  ////////////////////////////////////////////////////////////////////////
  // core hookup
  assign cif.gate_enable     = s_q.gate_enable;
  assign cif.gate_invert     = s_q.gate_invert;
  assign cif.function_select = s_q.function_select;
  assign cif.cell_enable     = s_q.cell_enable;

  for (genvar k = 0; k < lcc_pkg::GATE_COUNT; k++) begin : g_select
    assign cif.data_in[k] = SOURCES[s_q.data_source[k]];
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes
  assign S_AXI_AWREADY = !s_q.aw_held && !s_q.bvalid;
  assign S_AXI_WREADY  = !s_q.w_held && !s_q.bvalid;
  assign S_AXI_ARREADY = !s_q.rvalid;
  assign S_AXI_BVALID  = s_q.bvalid;
  assign S_AXI_BRESP   = s_q.bresp;
  assign S_AXI_RVALID  = s_q.rvalid;
  assign S_AXI_RDATA   = s_q.rdata;
  assign S_AXI_RRESP   = s_q.rresp;
  assign CELL_OUT      = s_q.out_q;
  assign CELL_IRQ_FLAG = s_q.cell_irq_flag;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    wbyte = s_q.w_data[7:0];
    widx = map_index(s_q.aw_addr);
    ridx = map_index(S_AXI_ARADDR);
    irq_clr = 1'b0;

    // enable gate and output polarity stage
    s_d.out_q = s_q.cell_enable & (cif.result ^ s_q.output_invert);
    // edges against the previous registered output
    s_d.out_prev = s_q.out_q;
    rise = s_q.out_q & ~s_q.out_prev;
    fall = ~s_q.out_q & s_q.out_prev;
    irq_set = (rise & s_q.rise_irq_enable) | (fall & s_q.fall_irq_enable);

    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_d.w_held = 1'b1;
      s_d.w_data = S_AXI_WDATA;
      s_d.w_strb = S_AXI_WSTRB;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (widx == lcc_pkg::IDX_NONE) ? lcc_pkg::RESP_SLVERR : lcc_pkg::RESP_OKAY;
      // only byte lane 0 holds register bits
      if (s_q.w_strb[0]) begin
        case (widx)
          // status and bit six are not writable
          lcc_pkg::IDX_CONTROL: begin
            s_d.cell_enable     = wbyte[lcc_pkg::CTL_ENABLE_BIT];
            s_d.rise_irq_enable = wbyte[lcc_pkg::CTL_RISE_BIT];
            s_d.fall_irq_enable = wbyte[lcc_pkg::CTL_FALL_BIT];
            s_d.function_select = wbyte[lcc_pkg::CTL_MODE_LSB +: lcc_pkg::MODE_WIDTH];
          end
          lcc_pkg::IDX_POLARITY: begin
            s_d.output_invert = wbyte[lcc_pkg::POL_OUTPUT_BIT];
            s_d.gate_invert   = wbyte[3:0];
          end
          lcc_pkg::IDX_SELECT0:         s_d.data_source[0] = wbyte[5:0];
          lcc_pkg::IDX_SELECT0 + 4'h1:  s_d.data_source[1] = wbyte[5:0];
          lcc_pkg::IDX_SELECT0 + 4'h2:  s_d.data_source[2] = wbyte[5:0];
          lcc_pkg::IDX_SELECT0 + 4'h3:  s_d.data_source[3] = wbyte[5:0];
          lcc_pkg::IDX_GATE0:           s_d.gate_enable[0] = wbyte;
          lcc_pkg::IDX_GATE0 + 4'h1:    s_d.gate_enable[1] = wbyte;
          lcc_pkg::IDX_GATE0 + 4'h2:    s_d.gate_enable[2] = wbyte;
          lcc_pkg::IDX_GATE0 + 4'h3:    s_d.gate_enable[3] = wbyte;
          lcc_pkg::IDX_IRQ:             irq_clr = wbyte[lcc_pkg::IRQ_FLAG_BIT];
          default:                      irq_clr = 1'b0;
        endcase
      end
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end

    rbyte = 8'h00;
    case (ridx)
      lcc_pkg::IDX_CONTROL: begin
        rbyte[lcc_pkg::CTL_ENABLE_BIT] = s_q.cell_enable;
        rbyte[lcc_pkg::CTL_STATUS_BIT] = s_q.out_q;
        rbyte[lcc_pkg::CTL_RISE_BIT]   = s_q.rise_irq_enable;
        rbyte[lcc_pkg::CTL_FALL_BIT]   = s_q.fall_irq_enable;
        rbyte[lcc_pkg::CTL_MODE_LSB +: lcc_pkg::MODE_WIDTH] = s_q.function_select;
      end
      lcc_pkg::IDX_POLARITY: begin
        rbyte[lcc_pkg::POL_OUTPUT_BIT] = s_q.output_invert;
        rbyte[3:0] = s_q.gate_invert;
      end
      lcc_pkg::IDX_SELECT0:        rbyte[5:0] = s_q.data_source[0];
      lcc_pkg::IDX_SELECT0 + 4'h1: rbyte[5:0] = s_q.data_source[1];
      lcc_pkg::IDX_SELECT0 + 4'h2: rbyte[5:0] = s_q.data_source[2];
      lcc_pkg::IDX_SELECT0 + 4'h3: rbyte[5:0] = s_q.data_source[3];
      lcc_pkg::IDX_GATE0:          rbyte = s_q.gate_enable[0];
      lcc_pkg::IDX_GATE0 + 4'h1:   rbyte = s_q.gate_enable[1];
      lcc_pkg::IDX_GATE0 + 4'h2:   rbyte = s_q.gate_enable[2];
      lcc_pkg::IDX_GATE0 + 4'h3:   rbyte = s_q.gate_enable[3];
      lcc_pkg::IDX_IRQ:            rbyte[lcc_pkg::IRQ_FLAG_BIT] = s_q.cell_irq_flag;
      default:                     rbyte = 8'h00;
    endcase
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = {24'h000000, rbyte};
      s_d.rresp = (ridx == lcc_pkg::IDX_NONE) ? lcc_pkg::RESP_SLVERR : lcc_pkg::RESP_OKAY;
    end
    if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end

    // set wins over a same-cycle clear
    s_d.cell_irq_flag = (s_q.cell_irq_flag & ~irq_clr) | irq_set;

    // reset touches control, output invert, flag and bus state; other config is kept
    if (RST) begin
      s_d.cell_enable     = lcc_pkg::CELL_CONTROL_RESET[lcc_pkg::CTL_ENABLE_BIT];
      s_d.rise_irq_enable = lcc_pkg::CELL_CONTROL_RESET[lcc_pkg::CTL_RISE_BIT];
      s_d.fall_irq_enable = lcc_pkg::CELL_CONTROL_RESET[lcc_pkg::CTL_FALL_BIT];
      s_d.function_select = lcc_pkg::CELL_CONTROL_RESET[lcc_pkg::CTL_MODE_LSB +: lcc_pkg::MODE_WIDTH];
      s_d.output_invert   = lcc_pkg::POL_OUTPUT_RESET;
      s_d.out_q           = 1'b0;
      s_d.out_prev        = 1'b0;
      s_d.cell_irq_flag   = 1'b0;
      s_d.aw_held         = 1'b0;
      s_d.aw_addr         = 8'h00;
      s_d.w_held          = 1'b0;
      s_d.w_data          = 32'h00000000;
      s_d.w_strb          = 4'h0;
      s_d.bvalid          = 1'b0;
      s_d.bresp           = lcc_pkg::RESP_OKAY;
      s_d.rvalid          = 1'b0;
      s_d.rdata           = 32'h00000000;
      s_d.rresp           = lcc_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_write_ready;
    s_q.aw_held && s_q.w_held && !s_q.bvalid && s_q.w_strb[0];
  endsequence
  sequence s_select0_write;
    s_write_ready ##0 (s_q.aw_addr == lcc_pkg::INPUT_SELECT_0_ADDR);
  endsequence
  sequence s_control_read;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == lcc_pkg::CELL_CONTROL_ADDR;
  endsequence

  a_disabled_zero: assert property (!s_q.cell_enable |=> !CELL_OUT)
    else $error("disabled cell output not zero");
  a_status_bit: assert property (s_control_read |=> S_AXI_RVALID && S_AXI_RDATA[5] == $past(CELL_OUT)
    && !S_AXI_RDATA[6]) else $error("control read status wrong");
  a_rise_sets: assert property (s_q.rise_irq_enable && CELL_OUT && !s_q.out_prev |=> CELL_IRQ_FLAG)
    else $error("rising edge did not set flag");
  a_fall_sets: assert property (s_q.fall_irq_enable && !CELL_OUT && s_q.out_prev |=> CELL_IRQ_FLAG)
    else $error("falling edge did not set flag");
  a_output_invert: assert property (s_q.cell_enable |=> CELL_OUT == ($past(cif.result) ^ $past(s_q.output_invert)))
    else $error("output polarity stage wrong");
  a_select_write: assert property (s_select0_write |=> S_AXI_BVALID
    && s_q.data_source[0] == $past(s_q.w_data[5:0])) else $error("select write lost");
  a_select_upper: assert property (S_AXI_ARVALID && S_AXI_ARREADY && ridx[3:2] == 2'h0 && ridx[1]
    |=> S_AXI_RDATA[31:6] == 26'h0) else $error("select upper bits not zero");
  a_set_beats_clear: assert property (irq_set && irq_clr |=> CELL_IRQ_FLAG)
    else $error("edge lost during flag clear");
  a_flag_holds: assert property (!CELL_IRQ_FLAG && !irq_set |=> !CELL_IRQ_FLAG)
    else $error("flag set without edge");
  // reset is the trigger here, so the default disable must not mask it
  a_reset_control: assert property (@(posedge SYS_CLK) disable iff (1'b0) RST |=> !s_q.cell_enable
    && !CELL_OUT && s_q.function_select == 3'h0 && !CELL_IRQ_FLAG && !S_AXI_BVALID)
    else $error("reset left control set");
endmodule : lcc_top
`default_nettype wire

// File: design/lcc_pkg.sv
`default_nettype none
package lcc_pkg;
  // byte addresses of the register words
  localparam logic [7:0] CELL_CONTROL_ADDR   = 8'h00;
  localparam logic [7:0] CELL_POLARITY_ADDR  = 8'h04;
  localparam logic [7:0] INPUT_SELECT_0_ADDR = 8'h08;
  localparam logic [7:0] INPUT_SELECT_1_ADDR = 8'h0c;
  localparam logic [7:0] INPUT_SELECT_2_ADDR = 8'h10;
  localparam logic [7:0] INPUT_SELECT_3_ADDR = 8'h14;
  localparam logic [7:0] GATE_ENABLE_0_ADDR  = 8'h18;
  localparam logic [7:0] GATE_ENABLE_1_ADDR  = 8'h1c;
  localparam logic [7:0] GATE_ENABLE_2_ADDR  = 8'h20;
  localparam logic [7:0] GATE_ENABLE_3_ADDR  = 8'h24;
  localparam logic [7:0] CELL_IRQ_ADDR       = 8'h28;

  // register indices returned by the address decoder
  localparam logic [3:0] IDX_CONTROL  = 4'h0;
  localparam logic [3:0] IDX_POLARITY = 4'h1;
  localparam logic [3:0] IDX_SELECT0  = 4'h2;
  localparam logic [3:0] IDX_GATE0    = 4'h6;
  localparam logic [3:0] IDX_IRQ      = 4'ha;
  localparam logic [3:0] IDX_NONE     = 4'hf;

  // cell_control fields
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_UNUSED_BIT = 6;
  localparam int CTL_STATUS_BIT = 5;
  localparam int CTL_RISE_BIT   = 4;
  localparam int CTL_FALL_BIT   = 3;
  localparam int CTL_MODE_LSB   = 0;
  localparam int MODE_WIDTH     = 3;
  localparam logic [7:0] CELL_CONTROL_RESET = 8'h00;

  // cell_polarity fields
  localparam int POL_OUTPUT_BIT = 7;
  localparam logic POL_OUTPUT_RESET = 1'b0;

  // input selects, gate enables and the irq flag bit
  localparam int SOURCE_WIDTH = 6;
  localparam int GATE_COUNT   = 4;
  localparam int IRQ_FLAG_BIT = 0;

  // function select codes
  localparam logic [2:0] MODE_AND_OR   = 3'h0;
  localparam logic [2:0] MODE_OR_XOR   = 3'h1;
  localparam logic [2:0] MODE_AND4     = 3'h2;
  localparam logic [2:0] MODE_SR_LATCH = 3'h3;
  localparam logic [2:0] MODE_DFF_SR   = 3'h4;
  localparam logic [2:0] MODE_DFF2_R   = 3'h5;
  localparam logic [2:0] MODE_JK_R     = 3'h6;
  localparam logic [2:0] MODE_LATCH_SR = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic                         cell_enable;
    logic                         rise_irq_enable;
    logic                         fall_irq_enable;
    logic [2:0]                   function_select;
    logic                         output_invert;
    logic [3:0]                   gate_invert;
    logic [3:0][5:0]              data_source;
    logic [3:0][7:0]              gate_enable;
    logic                         out_q;
    logic                         out_prev;
    logic                         cell_irq_flag;
    logic                         aw_held;
    logic [7:0]                   aw_addr;
    logic                         w_held;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
  } lcc_state_type;
endpackage : lcc_pkg
`default_nettype wire

// File: design/lcc_core_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lcc_core_if;
  logic [3:0]      data_in;
  logic [3:0][7:0] gate_enable;
  logic [3:0]      gate_invert;
  logic [2:0]      function_select;
  logic            cell_enable;
  logic            result;

  modport ctl (output data_in, gate_enable, gate_invert, function_select, cell_enable, input result);
  modport core (input data_in, gate_enable, gate_invert, function_select, cell_enable, output result);
endinterface : lcc_core_if
`default_nettype wire

// File: design/lcc_core.sv
`timescale 1ns/1ns
`default_nettype none
module lcc_core (
  input wire logic  clk,
  input wire logic  rst,
  lcc_core_if.core  cif
);
  typedef struct packed {
    logic store;
    logic gclk_prev;
  } lcc_core_state_type;

  lcc_core_state_type s_q;
  lcc_core_state_type s_d;
  logic [3:0]         g;
  logic               gedge;
  logic               comb;
  logic               stored;

  // or of every enabled true or negated term
  function automatic logic gate_or(input logic [7:0] en, input logic [3:0] d);
    logic t;
    t = 1'b0;
    for (int k = 0; k < 4; k++) begin
      t = t | (en[2*k+1] & d[k]) | (en[2*k] & ~d[k]);
    end
    return t;
  endfunction : gate_or

  for (genvar i = 0; i < lcc_pkg::GATE_COUNT; i++) begin : g_gate
    assign g[i] = gate_or(cif.gate_enable[i], cif.data_in) ^ cif.gate_invert[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // storage elements are emulated on the system clock; gate 0 rising edges clock the flip-flop modes
  always_comb begin
    s_d = s_q;
    s_d.gclk_prev = g[0];
    gedge = g[0] & ~s_q.gclk_prev;
    comb = 1'b0;
    stored = 1'b1;
    case (cif.function_select)
      lcc_pkg::MODE_AND_OR: begin
        comb = (g[0] & g[1]) | (g[2] & g[3]);
        stored = 1'b0;
      end
      lcc_pkg::MODE_OR_XOR: begin
        comb = (g[0] | g[1]) ^ (g[2] | g[3]);
        stored = 1'b0;
      end
      lcc_pkg::MODE_AND4: begin
        comb = &g;
        stored = 1'b0;
      end
      lcc_pkg::MODE_SR_LATCH: s_d.store = (g[0] | g[1]) | (~(g[2] | g[3]) & s_q.store);
      lcc_pkg::MODE_DFF_SR: begin
        if (g[2]) s_d.store = 1'b0;
        else if (g[3]) s_d.store = 1'b1;
        else if (gedge) s_d.store = g[1];
      end
      lcc_pkg::MODE_DFF2_R: begin
        if (g[2]) s_d.store = 1'b0;
        else if (gedge) s_d.store = g[1] & g[3];
      end
      lcc_pkg::MODE_JK_R: begin
        if (g[2]) s_d.store = 1'b0;
        else if (gedge) s_d.store = (g[1] & ~s_q.store) | (~g[3] & s_q.store);
      end
      // transparent latch while gate 0 high
      lcc_pkg::MODE_LATCH_SR: begin
        if (g[2]) s_d.store = 1'b0;
        else if (g[3]) s_d.store = 1'b1;
        else if (g[0]) s_d.store = g[1];
      end
      default: stored = 1'b0;
    endcase
    cif.result = stored ? s_d.store : comb;
    if (rst || !cif.cell_enable) begin
      s_d.store = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // gate setup is unknown until written, so only an enabled cell is held to it
  a_and_or_mode: assert property (cif.cell_enable && cif.function_select == lcc_pkg::MODE_AND_OR |->
    cif.result == ((g[0] & g[1]) | (g[2] & g[3]))) else $error("and-or result wrong");
  a_latch_reset: assert property (cif.cell_enable && cif.function_select == lcc_pkg::MODE_LATCH_SR
    && g[2] |-> !cif.result) else $error("latch reset ignored");
endmodule : lcc_core
`default_nettype wire

// File: tb/lcc_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module lcc_top_bench;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [63:0] sources;
  logic        cell_out;
  logic        cell_irq_flag;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // storage mode steps, {expected output, sources[63:60]} x5, first step in the top bits
  localparam logic [24:0] SEQ_TAB [3:7] = '{{5'h11, 5'h10, 5'h04, 5'h00, 5'h11},
    {5'h02, 5'h13, 5'h10, 5'h04, 5'h18}, {5'h0a, 5'h1b, 5'h0f, 5'h0a, 5'h1b},
    {5'h02, 5'h13, 5'h1a, 5'h0b, 5'h02}, {5'h13, 5'h01, 5'h00, 5'h02, 5'h18}};

  lcc_top dut (.SYS_CLK(sys_clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SOURCES(sources),
    .CELL_OUT(cell_out), .CELL_IRQ_FLAG(cell_irq_flag));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // aw and w offered together, each released at its own accepting edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    `CHK("bresp", er, bresp)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er = 2'h0);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    `CHK("rdata", {24'h000000, ed}, rdata)
    `CHK("rresp", er, rresp)
  endtask : rd

  // four edges cover the output and flag registers with margin
  task automatic apply(input logic [3:0] s, input logic eo);
    sources <= {s, 60'h0};
    repeat (4) @(posedge sys_clk);
    `CHK("cell_out", eo, cell_out)
  endtask : apply

  function automatic logic comb(input logic [2:0] m, input logic [3:0] g);
    case (m)
      3'h0: comb = (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: comb = (g[0] | g[1]) ^ (g[2] | g[3]);
      default: comb = &g;
    endcase
  endfunction : comb

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] gi;
    logic       e;
    logic [4:0] st;
    rst = 1'b1;
    {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
    wstrb   = 4'hf;
    bready  = 1'b1;
    rready  = 1'b1;
    sources = 64'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(lcc_pkg::CELL_CONTROL_ADDR, 8'h00);
    `CHK("cell_out", 1'b0, cell_out)
    wr(lcc_pkg::CELL_CONTROL_ADDR, 8'h5f);
    rd(lcc_pkg::CELL_CONTROL_ADDR, 8'h1f);
    wr(lcc_pkg::CELL_POLARITY_ADDR, 8'hff);
    rd(lcc_pkg::CELL_POLARITY_ADDR, 8'h8f);
    // top source codes, upper bits dropped
    for (int k = 0; k < 4; k++) begin
      wr(lcc_pkg::INPUT_SELECT_0_ADDR + 8'(4 * k), 8'hfc + 8'(k));
      rd(lcc_pkg::INPUT_SELECT_0_ADDR + 8'(4 * k), 8'h3c + 8'(k));
    end
    wr(8'h2c, 8'h00, lcc_pkg::RESP_SLVERR);
    rd(8'h2c, 8'h00, lcc_pkg::RESP_SLVERR);
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      gi = (p == 1) ? 4'h5 : 4'h0;
      for (int k = 0; k < 4; k++) begin
        wr(lcc_pkg::GATE_ENABLE_0_ADDR + 8'(4 * k), (p == 1) ? 8'h01 << (2 * k) : 8'h02 << (2 * k));
      end
      wr(lcc_pkg::CELL_POLARITY_ADDR, {p[0], 3'h0, gi});
      for (int m = 0; m < 3; m++) begin
        wr(lcc_pkg::CELL_CONTROL_ADDR, 8'h80 | 8'(m));
        for (int s = 0; s < 16; s++) begin
          e = comb(3'(m), ((p == 1) ? ~4'(s) : 4'(s)) ^ gi) ^ p[0];
          apply(4'(s), e);
          rd(lcc_pkg::CELL_CONTROL_ADDR, {2'b10, e, 2'b00, 3'(m)});
        end
      end
    end
    // disabled cell stays low even with output inverted
    wr(lcc_pkg::CELL_CONTROL_ADDR, 8'h02);
    apply(4'h0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(lcc_pkg::GATE_ENABLE_0_ADDR + 8'(4 * k), 8'h02 << (2 * k));
    end
    wr(lcc_pkg::CELL_POLARITY_ADDR, 8'h00);
    $display("test functions done");
    // storage modes, cleared by disabling between them
    for (int m = 3; m < 8; m++) begin
      wr(lcc_pkg::CELL_CONTROL_ADDR, 8'h00);
      apply(4'h0, 1'b0);
      wr(lcc_pkg::CELL_CONTROL_ADDR, 8'h80 | 8'(m));
      for (int i = 0; i < 5; i++) begin
        st = SEQ_TAB[m][24 - 5 * i -: 5];
        apply(st[3:0], st[4]);
      end
    end
    $display("test storage done");
    wr(lcc_pkg::CELL_CONTROL_ADDR, 8'h92);
    apply(4'h0, 1'b0);
    wr(lcc_pkg::CELL_IRQ_ADDR, 8'h01);
    `CHK("flag", 1'b0, cell_irq_flag)
    apply(4'hf, 1'b1);
    `CHK("flag", 1'b1, cell_irq_flag)
    rd(lcc_pkg::CELL_IRQ_ADDR, 8'h01);
    wr(lcc_pkg::CELL_IRQ_ADDR, 8'h01);
    `CHK("flag", 1'b0, cell_irq_flag)
    apply(4'h0, 1'b0);
    `CHK("flag", 1'b0, cell_irq_flag)
    wr(lcc_pkg::CELL_CONTROL_ADDR, 8'h8a);
    apply(4'hf, 1'b1);
    `CHK("flag", 1'b0, cell_irq_flag)
    apply(4'h0, 1'b0);
    `CHK("flag", 1'b1, cell_irq_flag)
    wr(lcc_pkg::CELL_IRQ_ADDR, 8'h01);
    wr(lcc_pkg::CELL_POLARITY_ADDR, 8'h80);
    apply(4'h0, 1'b1);
    `CHK("flag", 1'b0, cell_irq_flag)
    wr(lcc_pkg::CELL_POLARITY_ADDR, 8'h05);
    apply(4'h0, 1'b0);
    `CHK("flag", 1'b1, cell_irq_flag)
    apply(4'ha, 1'b1);
    wr(lcc_pkg::CELL_IRQ_ADDR, 8'h01);
    // falling edge lands in the cycle the clearing write is applied
    sources <= 64'h0;
    wr(lcc_pkg::CELL_IRQ_ADDR, 8'h01);
    `CHK("flag", 1'b1, cell_irq_flag)
    $display("test interrupt done");
    // reset in mid-run keeps the selection
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK("flag", 1'b0, cell_irq_flag)
    rd(lcc_pkg::CELL_CONTROL_ADDR, 8'h00);
    rd(lcc_pkg::CELL_POLARITY_ADDR, 8'h05);
    rd(lcc_pkg::INPUT_SELECT_1_ADDR, 8'h3d);
    rd(lcc_pkg::GATE_ENABLE_0_ADDR, 8'h02);
    $display("test reset done");
    finish_test();
  end
endmodule : lcc_top_bench
`undef CHK
`default_nettype wire
